//--- design/rla_regs.svh
// Register offsets, field positions, reset values and encodings for the
// route table indirect access block.
// Assumes byte addressing on a 20-bit register port with 32-bit data.
//
// Functional notes
// - Select register plus port register reach one entry
// - Auto-increment bumps selected ID after each access
// - Parity flip bit stores inverted parity on writes
// - Inverted-parity entry flags error on route lookup
// - Bits 16..23 give upper destination ID byte
// - Bits 24..31 give lower destination ID byte
// - Port field in low byte routes the ID
// - Port value at or above total marks unmapped
// - Unmapped entry reads back as all-ones
// - Table mode: global by upper byte, or 512-local
`ifndef RLA_REGS_SVH
`define RLA_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RLA_OFS_SELECT 20'h1_0070
`define RLA_OFS_PORT 20'h1_0074
`define RLA_OFS_CFG 20'h1_0080
`define RLA_OFS_INT_STAT 20'h1_0084
`define RLA_OFS_INT_MASK 20'h1_0088

// ----------------------------------------------------------------
// Field positions (bit 31 is the leftmost documented bit 0)
// ----------------------------------------------------------------
`define RLA_BIT_AUTO_INC 31
`define RLA_BIT_PAR_FLIP 30
`define RLA_BIT_TABLE_MODE 24
`define RLA_INT_PARITY 0
`define RLA_INT_UNMAPPED 1

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define RLA_SEL_RESET 16'h0000
`define RLA_TABLE_MODE_RESET 1'b1
`define RLA_PORT_UNMAPPED 8'hFF
`define RLA_LUT_DEPTH 512
`define RLA_PORT_TOTAL 16

`endif

//--- design/rla_pkg.sv
// Types and shared decode for the route table indirect access block.
// Assumes the constants header is compiled alongside.
`default_nettype none
package rla_pkg;

  // One stored table entry: parity above the port number
  typedef struct packed {
    logic par;
    logic [7:0] port;
  } rla_entry_t;

  // Source of the registered read data
  typedef enum logic [1:0] {
    RSEL_ZERO,
    RSEL_HOLD,
    RSEL_PORT
  } rla_rsel_t;

  // Table index from the 16-bit destination ID and the table mode
  function automatic logic [8:0] rla_lut_index(input logic [15:0] id, input logic local_mode);
    rla_lut_index = local_mode ? id[8:0] : {1'b0, id[15:8]};
  endfunction : rla_lut_index

  // A port number at or above the port count means unmapped
  function automatic logic rla_is_unmapped(input logic [7:0] port, input logic [8:0] total);
    rla_is_unmapped = ({1'b0, port} >= total);
  endfunction : rla_is_unmapped

endpackage : rla_pkg
`default_nettype wire

//--- design/rla_lut_if.sv
// Carrier between the access logic, the lookup path and the table memory.
// Port a is the software access port, port b the routing lookup port.
`timescale 1ns/1ps
`default_nettype none
interface rla_lut_if #(
  parameter int AW = 9,
  parameter int DW = 9
);
  logic a_en;
  logic a_we;
  logic [AW-1:0] a_addr;
  logic [DW-1:0] a_wdata;
  logic [DW-1:0] a_rdata;
  logic b_en;
  logic [AW-1:0] b_addr;
  logic [DW-1:0] b_rdata;

  modport mem (input a_en, a_we, a_addr, a_wdata, b_en, b_addr, output a_rdata, b_rdata);
  modport acc (output a_en, a_we, a_addr, a_wdata, input a_rdata);
  modport look (output b_en, b_addr, input b_rdata);
endinterface : rla_lut_if
`default_nettype wire

//--- design/rla_lut_mem.sv
// Route table storage: one read/write port and one read-only port.
// Read data come out of registers one cycle after the enable.
`timescale 1ns/1ps
`default_nettype none
module rla_lut_mem #(
  parameter int DEPTH = 512,
  parameter int AW = 9,
  parameter int DW = 9
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  rla_lut_if.mem lut
);
  // Entries have no reset; their content is undefined until written
  logic [DW-1:0] mem_q [DEPTH];

  // ------------------------------------------------------------
  // Array write and registered reads
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce && lut.a_en && lut.a_we) begin
      mem_q[lut.a_addr] <= lut.a_wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lut.a_rdata <= '0;
      lut.b_rdata <= '0;
    end else if (ce) begin
      // Read before write on port a
      if (lut.a_en) begin
        lut.a_rdata <= mem_q[lut.a_addr];
      end
      if (lut.b_en) begin
        lut.b_rdata <= mem_q[lut.b_addr];
      end
    end
  end
endmodule : rla_lut_mem
`default_nettype wire

//--- design/rla_route_lookup.sv
// Routing lookup path: destination ID in, port and parity check out.
// Assumes the requester is on the same clock; result is two cycles later.
`timescale 1ns/1ps
`default_nettype none
`include "rla_regs.svh"
module rla_route_lookup
  import rla_pkg::*;
#(
  parameter int PORT_TOTAL = `RLA_PORT_TOTAL
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic table_mode,
  input wire logic req_valid,
  input wire logic [15:0] req_dest_id,
  rla_lut_if.look lut,
  output logic done,
  output logic [7:0] port,
  output logic parity_err,
  output logic unmapped
);
  localparam logic [8:0] TOTAL = 9'(PORT_TOTAL);

  logic stage_r, stage_nxt;       // Memory read in flight
  logic done_r, done_nxt;
  logic [7:0] port_r, port_nxt;
  logic perr_r, perr_nxt;
  logic unm_r, unm_nxt;
  rla_entry_t ent;

  // Lookup picks global or local index
  assign lut.b_en = req_valid;
  assign lut.b_addr = rla_lut_index(req_dest_id, table_mode);
  assign ent = rla_entry_t'(lut.b_rdata);

  // ------------------------------------------------------------
  // Result stage
  // ------------------------------------------------------------
  always_comb begin
    stage_nxt = req_valid;
    done_nxt = stage_r;
    port_nxt = port_r;
    perr_nxt = 1'b0;
    unm_nxt = 1'b0;
    if (stage_r) begin
      // Even parity over port and parity bit must be zero
      perr_nxt = ^{ent.par, ent.port};
      unm_nxt = rla_is_unmapped(ent.port, TOTAL);
      port_nxt = unm_nxt ? `RLA_PORT_UNMAPPED : ent.port;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_r <= 1'b0;
      done_r <= 1'b0;
      port_r <= 8'h00;
      perr_r <= 1'b0;
      unm_r <= 1'b0;
    end else if (ce) begin
      stage_r <= stage_nxt;
      done_r <= done_nxt;
      port_r <= port_nxt;
      perr_r <= perr_nxt;
      unm_r <= unm_nxt;
    end
  end

  assign done = done_r;
  assign port = port_r;
  assign parity_err = perr_r;
  assign unmapped = unm_r;

  // Global mode never reaches the upper half of the table
  a_global_index_range: assert property (@(posedge clk) disable iff (rst)
    (req_valid && !table_mode) |-> (lut.b_addr[8] == 1'b0 && lut.b_addr[7:0] == req_dest_id[15:8]))
    else $error("global index not taken from upper byte");
endmodule : rla_route_lookup
`default_nettype wire

//--- design/rla_route_lut_access.sv
// Indirect access to the route table: select register, port register,
// configuration, interrupt status and mask, plus the lookup path.
// Assumes a single-cycle strobe register master on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "rla_regs.svh"
module rla_route_lut_access
  import rla_pkg::*;
#(
  parameter int PORT_TOTAL = `RLA_PORT_TOTAL,
  parameter int LUT_DEPTH = `RLA_LUT_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [19:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic lookup_valid,
  input wire logic [15:0] lookup_dest_id,
  output logic lookup_done,
  output logic [7:0] lookup_port,
  output logic lookup_parity_err,
  output logic lookup_unmapped,
  output logic irq
);
  // ----------------------------------------------------------------
  // Local constants and state
  // ----------------------------------------------------------------
  localparam logic [8:0] TOTAL = 9'(PORT_TOTAL);

  // Select register fields
  logic auto_inc_r, auto_inc_nxt;     // Post-increment enable
  logic par_flip_r, par_flip_nxt;     // Test: store inverted parity
  logic [15:0] sel_id_r, sel_id_nxt;  // Upper byte over lower byte

  // Configuration
  logic table_mode_r, table_mode_nxt; // 1: one 512-entry local table

  // Interrupt status and mask
  logic [1:0] int_stat_r, int_stat_nxt;
  logic [1:0] int_mask_r, int_mask_nxt;

  // Read data path
  rla_rsel_t rsel_r, rsel_nxt;        // Which source answers
  logic [31:0] hold_r, hold_nxt;      // Plain register read value

  // Decoded strobes
  logic hit_sel, hit_port, hit_cfg, hit_stat, hit_mask;
  logic port_acc;                     // Port register read or write
  logic [1:0] events;                 // Lookup events this cycle
  logic [7:0] wr_port;                // Port value as it will be stored
  rla_entry_t rd_ent;                 // Entry returned by the table

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  rla_lut_if #(.AW(9), .DW(9)) lut_if ();

  rla_lut_mem #(
    .DEPTH(LUT_DEPTH),
    .AW(9),
    .DW(9)
  ) u_mem (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .lut(lut_if.mem)
  );

  rla_route_lookup #(
    .PORT_TOTAL(PORT_TOTAL)
  ) u_lookup (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .table_mode(table_mode_r),
    .req_valid(lookup_valid),
    .req_dest_id(lookup_dest_id),
    .lut(lut_if.look),
    .done(lookup_done),
    .port(lookup_port),
    .parity_err(lookup_parity_err),
    .unmapped(lookup_unmapped)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Unmapped addresses match nothing: writes drop, reads give zero
  always_comb begin
    hit_sel = (reg_addr == `RLA_OFS_SELECT);
    hit_port = (reg_addr == `RLA_OFS_PORT);
    hit_cfg = (reg_addr == `RLA_OFS_CFG);
    hit_stat = (reg_addr == `RLA_OFS_INT_STAT);
    hit_mask = (reg_addr == `RLA_OFS_INT_MASK);
    port_acc = hit_port && (reg_wr || reg_rd);
  end

  // ----------------------------------------------------------------
  // Table access through the port register
  // ----------------------------------------------------------------
  // Out-of-range values collapse to the all-ones code, the same code
  // software is asked to use, so a read never shows a stale number
  always_comb begin
    wr_port = reg_wdata[7:0];
    if (rla_is_unmapped(reg_wdata[7:0], TOTAL)) begin
      wr_port = `RLA_PORT_UNMAPPED;
    end
  end

  // Entry chosen by the selected ID, written with optional bad parity
  assign lut_if.a_en = port_acc;
  assign lut_if.a_we = hit_port && reg_wr;
  assign lut_if.a_addr = rla_lut_index(sel_id_r, table_mode_r);
  assign lut_if.a_wdata = {(^wr_port) ^ par_flip_r, wr_port};
  assign rd_ent = rla_entry_t'(lut_if.a_rdata);

  // ----------------------------------------------------------------
  // Select register
  // ----------------------------------------------------------------
  // Software write loads all fields; an access through the port
  // register then advances the ID when post-increment is on
  always_comb begin
    auto_inc_nxt = auto_inc_r;
    par_flip_nxt = par_flip_r;
    sel_id_nxt = sel_id_r;
    if (reg_wr && hit_sel) begin
      auto_inc_nxt = reg_wdata[`RLA_BIT_AUTO_INC];
      par_flip_nxt = reg_wdata[`RLA_BIT_PAR_FLIP];
      sel_id_nxt = {reg_wdata[15:8], reg_wdata[7:0]};
    end else if (port_acc && auto_inc_r) begin
      // Carries from the lower byte into the upper byte
      sel_id_nxt = sel_id_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      auto_inc_r <= 1'b0;
      par_flip_r <= 1'b0;
      sel_id_r <= `RLA_SEL_RESET;
    end else if (ce) begin
      auto_inc_r <= auto_inc_nxt;
      par_flip_r <= par_flip_nxt;
      sel_id_r <= sel_id_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Configuration, interrupt status and mask
  // ----------------------------------------------------------------
  // Lookup events: bad parity and unmapped destination
  always_comb begin
    events = 2'b00;
    events[`RLA_INT_PARITY] = lookup_done && lookup_parity_err;
    events[`RLA_INT_UNMAPPED] = lookup_done && lookup_unmapped;
  end

  // Write-one-to-clear; a new event in the same cycle wins
  always_comb begin
    table_mode_nxt = table_mode_r;
    int_mask_nxt = int_mask_r;
    int_stat_nxt = int_stat_r;
    if (reg_wr && hit_cfg) begin
      table_mode_nxt = reg_wdata[`RLA_BIT_TABLE_MODE];
    end
    if (reg_wr && hit_mask) begin
      int_mask_nxt = reg_wdata[1:0];
    end
    if (reg_wr && hit_stat) begin
      int_stat_nxt = int_stat_r & ~reg_wdata[1:0];
    end
    int_stat_nxt = int_stat_nxt | events;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      table_mode_r <= `RLA_TABLE_MODE_RESET;
      int_mask_r <= 2'b00;
      int_stat_r <= 2'b00;
    end else if (ce) begin
      table_mode_r <= table_mode_nxt;
      int_mask_r <= int_mask_nxt;
      int_stat_r <= int_stat_nxt;
    end
  end

  // Level interrupt while any unmasked status bit is set
  assign irq = |(int_stat_r & int_mask_r);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Plain registers are captured at the strobe; the port register is
  // answered from the table's own output register in the next cycle
  always_comb begin
    rsel_nxt = RSEL_ZERO;
    hold_nxt = 32'h0000_0000;
    if (reg_rd) begin
      rsel_nxt = RSEL_HOLD;
      // Reserved bits read as zero
      if (hit_sel) begin
        hold_nxt[`RLA_BIT_AUTO_INC] = auto_inc_r;
        hold_nxt[`RLA_BIT_PAR_FLIP] = par_flip_r;
        hold_nxt[15:0] = sel_id_r;
      end else if (hit_port) begin
        rsel_nxt = RSEL_PORT;
      end else if (hit_cfg) begin
        hold_nxt[`RLA_BIT_TABLE_MODE] = table_mode_r;
      end else if (hit_stat) begin
        hold_nxt[1:0] = int_stat_r;
      end else if (hit_mask) begin
        hold_nxt[1:0] = int_mask_r;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsel_r <= RSEL_ZERO;
      hold_r <= 32'h0000_0000;
    end else if (ce) begin
      rsel_r <= rsel_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Parity is not shown on reads, flipped or not
  always_comb begin
    case (rsel_r)
      RSEL_HOLD: reg_rdata = hold_r;
      RSEL_PORT: begin
        if (rla_is_unmapped(rd_ent.port, TOTAL)) begin
          reg_rdata = {24'h00_0000, `RLA_PORT_UNMAPPED};
        end else begin
          reg_rdata = {24'h00_0000, rd_ent.port};
        end
      end
      default: reg_rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_port_write;
    ce && reg_wr && hit_port && !auto_inc_r;
  endsequence

  sequence s_port_read;
    ce && reg_rd && hit_port;
  endsequence

  a_auto_inc_step: assert property (
    (ce && port_acc && auto_inc_r) |=> (sel_id_r == $past(sel_id_r) + 16'h0001))
    else $error("selected ID not advanced after port access");

  a_no_inc_hold: assert property (
    (ce && port_acc && !auto_inc_r) |=> $stable(sel_id_r))
    else $error("selected ID moved without post-increment");

  // Out-of-range port values must reach the table as the all-ones code
  a_unmapped_store: assert property (
    (ce && lut_if.a_we && rla_is_unmapped(reg_wdata[7:0], TOTAL)) |-> (lut_if.a_wdata[7:0] == `RLA_PORT_UNMAPPED))
    else $error("out-of-range port not stored as all ones");

  a_unmapped_back: assert property (
    (s_port_write ##0 rla_is_unmapped(reg_wdata[7:0], TOTAL)) ##1 s_port_read
    |=> reg_rdata == {24'h00_0000, `RLA_PORT_UNMAPPED})
    else $error("unmapped entry did not read back as all ones");

  a_mapped_round: assert property (
    (s_port_write ##0 !rla_is_unmapped(reg_wdata[7:0], TOTAL)) ##1 s_port_read
    |=> reg_rdata == {24'h00_0000, $past(reg_wdata[7:0], 2)})
    else $error("port value did not read back");

  a_flip_parity: assert property (
    (ce && lut_if.a_we) |-> (^lut_if.a_wdata) == par_flip_r)
    else $error("stored parity does not follow flip bit");

  a_select_reserved: assert property (
    (ce && reg_rd && hit_sel) |=> (reg_rdata[29:16] == 14'h0000 && reg_rdata[15:0] == $past(sel_id_r)))
    else $error("select register read wrong");

  a_parity_status: assert property (
    (ce && lookup_done && lookup_parity_err) |=> int_stat_r[`RLA_INT_PARITY] ##0
    (irq || !int_mask_r[`RLA_INT_PARITY]))
    else $error("parity error not latched");

endmodule : rla_route_lut_access
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the route table indirect access block.
// Assumes the design files and the constants header are compiled first,
// and that the header is reachable by its bare name.
`timescale 1ns/1ps
`default_nettype none
`include "rla_regs.svh"

// ------------------------------------------------------------
// Compare helper: counts every compare, reports a mismatch at once
// ------------------------------------------------------------
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end

module tb;
  localparam int PT = 16; // Port count handed to the design

  logic clk; // Core clock
  logic rst; // Async reset, active high
  logic ce; // Clock enable
  logic [19:0] reg_addr; // Register byte address
  logic [31:0] reg_wdata; // Register write data
  logic reg_wr; // Write strobe
  logic reg_rd; // Read strobe
  logic [31:0] reg_rdata; // Read data, one cycle after the strobe
  logic lookup_valid; // Routing lookup request
  logic [15:0] lookup_dest_id; // Destination ID to route
  logic lookup_done; // Lookup result strobe
  logic [7:0] lookup_port; // Port from the table
  logic lookup_parity_err; // Entry parity bad
  logic lookup_unmapped; // Entry unmapped
  logic irq; // Level interrupt
  int mismatches; // Failed compares
  int checked; // All compares

  // ------------------------------------------------------------
  // Device under test
  // ------------------------------------------------------------
  rla_route_lut_access #(.PORT_TOTAL(PT), .LUT_DEPTH(512)) rla_route_lut_access_inst (
    .clk(clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lookup_valid(lookup_valid),
    .lookup_dest_id(lookup_dest_id), .lookup_done(lookup_done), .lookup_port(lookup_port),
    .lookup_parity_err(lookup_parity_err), .lookup_unmapped(lookup_unmapped), .irq(irq)
  );

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Register bus tasks: strobes last one cycle, set after an edge
  // ------------------------------------------------------------
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic chk_rd(input logic [19:0] a, input logic [31:0] exp);
    logic [31:0] d;
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    `CHK(d, exp)
  endtask : chk_rd

  // Select register image: auto-increment, parity flip, 16-bit ID
  function automatic logic [31:0] sel(input logic ai, input logic fl, input logic [15:0] id);
    sel = {ai, fl, 14'h0000, id};
  endfunction : sel

  // Port write and port read back to back, no idle cycle between strobes
  task automatic wr_rd_port(input logic [7:0] p, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= `RLA_OFS_PORT;
    reg_wdata <= {24'h00_0000, p};
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask : wr_rd_port

  // Point at one ID and write its port
  task automatic put(input logic [15:0] id, input logic [7:0] p);
    wr(`RLA_OFS_SELECT, sel(1'b0, 1'b0, id));
    wr(`RLA_OFS_PORT, {24'h00_0000, p});
  endtask : put

  // Point at one ID and read its port back
  task automatic get(input logic [15:0] id, input logic [7:0] p);
    wr(`RLA_OFS_SELECT, sel(1'b0, 1'b0, id));
    chk_rd(`RLA_OFS_PORT, {24'h00_0000, p});
  endtask : get

  // ------------------------------------------------------------
  // Lookup task: result must land exactly two cycles after request
  // ------------------------------------------------------------
  task automatic look(input logic [15:0] id, input logic [7:0] ep, input logic ee, input logic eu);
    @(posedge clk);
    lookup_valid <= 1'b1;
    lookup_dest_id <= id;
    @(posedge clk);
    lookup_valid <= 1'b0;
    #1;
    `CHK(lookup_done, 1'b0)
    @(posedge clk);
    #1;
    `CHK(lookup_done, 1'b1)
    `CHK(lookup_port, ep)
    `CHK(lookup_parity_err, ee)
    `CHK(lookup_unmapped, eu)
  endtask : look

  // Interrupt is a level from registers; give it time to settle
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk);
    #1;
    `CHK(irq, e)
  endtask : chk_irq

  // Single place where the run ends
  task automatic final_report();
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mismatches = 0;
    checked = 0;
    rst = 1'b1;
    ce = 1'b1;
    reg_addr = 20'h0_0000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    lookup_valid = 1'b0;
    lookup_dest_id = 16'h0000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values of the select, configuration, status and mask registers
    chk_rd(`RLA_OFS_SELECT, 32'h0000_0000);
    chk_rd(`RLA_OFS_CFG, 32'h0100_0000);
    chk_rd(`RLA_OFS_INT_STAT, 32'h0000_0000);
    chk_rd(`RLA_OFS_INT_MASK, 32'h0000_0000);
    chk_irq(1'b0);
    // Reserved bits ignore writes; both ID bytes kept in place
    wr(`RLA_OFS_SELECT, 32'h3FFF_1234);
    chk_rd(`RLA_OFS_SELECT, 32'h0000_1234);
    // Unmapped address: write dropped, read gives zero
    wr(20'h1_0090, 32'hFFFF_FFFF);
    chk_rd(20'h1_0090, 32'h0000_0000);
    // Strobe while the clock enable is low is ignored
    @(posedge clk);
    ce <= 1'b0;
    wr(`RLA_OFS_SELECT, 32'h0000_0055);
    @(posedge clk);
    ce <= 1'b1;
    chk_rd(`RLA_OFS_SELECT, 32'h0000_1234);
    // Local table: upper byte feeds index bit 8, so these are two entries
    put(16'h0005, 8'h03);
    put(16'h0105, 8'h07);
    get(16'h0005, 8'h03);
    get(16'h0105, 8'h07);
    look(16'h0005, 8'h03, 1'b0, 1'b0);
    look(16'h0105, 8'h07, 1'b0, 1'b0);
    // Port boundary: last real port kept, port count and all-ones unmapped
    put(16'h0008, 8'h0F);
    put(16'h0006, 8'h10);
    put(16'h0007, 8'hFF);
    get(16'h0008, 8'h0F);
    get(16'h0006, 8'hFF);
    get(16'h0007, 8'hFF);
    // Unmapped lookup raises sticky status; mask gates the interrupt
    look(16'h0006, 8'hFF, 1'b0, 1'b1);
    chk_rd(`RLA_OFS_INT_STAT, 32'h0000_0002);
    chk_irq(1'b0);
    wr(`RLA_OFS_INT_MASK, 32'h0000_0002);
    chk_irq(1'b1);
    wr(`RLA_OFS_INT_STAT, 32'h0000_0002);
    chk_irq(1'b0);
    chk_rd(`RLA_OFS_INT_STAT, 32'h0000_0000);
    // Auto-increment on writes, carrying from the lower into the upper byte
    wr(`RLA_OFS_SELECT, sel(1'b1, 1'b0, 16'h00FE));
    wr(`RLA_OFS_PORT, 32'h0000_0001);
    wr(`RLA_OFS_PORT, 32'h0000_0002);
    wr(`RLA_OFS_PORT, 32'h0000_0003);
    chk_rd(`RLA_OFS_SELECT, sel(1'b1, 1'b0, 16'h0101));
    // Auto-increment on reads walks the same entries back
    wr(`RLA_OFS_SELECT, sel(1'b1, 1'b0, 16'h00FE));
    chk_rd(`RLA_OFS_PORT, 32'h0000_0001);
    chk_rd(`RLA_OFS_PORT, 32'h0000_0002);
    chk_rd(`RLA_OFS_PORT, 32'h0000_0003);
    chk_rd(`RLA_OFS_SELECT, sel(1'b1, 1'b0, 16'h0101));
    // Without the bit the selection stays put
    wr(`RLA_OFS_SELECT, sel(1'b0, 1'b0, 16'h0010));
    wr(`RLA_OFS_PORT, 32'h0000_0004);
    wr(`RLA_OFS_PORT, 32'h0000_0005);
    chk_rd(`RLA_OFS_SELECT, sel(1'b0, 1'b0, 16'h0010));
    look(16'h0010, 8'h05, 1'b0, 1'b0);
    // Parity flip: reads unaffected, lookups see a parity error
    wr(`RLA_OFS_SELECT, sel(1'b0, 1'b1, 16'h0020));
    wr(`RLA_OFS_PORT, 32'h0000_0005);
    chk_rd(`RLA_OFS_PORT, 32'h0000_0005);
    look(16'h0020, 8'h05, 1'b1, 1'b0);
    chk_rd(`RLA_OFS_INT_STAT, 32'h0000_0001);
    wr(`RLA_OFS_INT_MASK, 32'h0000_0001);
    chk_irq(1'b1);
    wr(`RLA_OFS_INT_STAT, 32'h0000_0001);
    chk_irq(1'b0);
    // Flip cleared: rewritten entry carries normal parity again
    put(16'h0020, 8'h05);
    look(16'h0020, 8'h05, 1'b0, 1'b0);
    // Read straight after a write sees the new entry, unmapped or not
    wr(`RLA_OFS_SELECT, sel(1'b0, 1'b0, 16'h0030));
    wr_rd_port(8'h20, 32'h0000_00FF);
    wr_rd_port(8'h0A, 32'h0000_000A);
    // Global table: only the upper byte indexes the entry
    wr(`RLA_OFS_CFG, 32'h0000_0000);
    chk_rd(`RLA_OFS_CFG, 32'h0000_0000);
    put(16'h0300, 8'h09);
    get(16'h0377, 8'h09);
    look(16'h03AB, 8'h09, 1'b0, 1'b0);
    // Back to the local table: index follows the low nine bits again
    wr(`RLA_OFS_CFG, 32'h0100_0000);
    look(16'h0005, 8'h03, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule : tb
`undef CHK
`default_nettype wire
